// ---- spt_cfg.svh ----
// configuration constants for the transmit pcs path
`ifndef SPT_CFG_SVH
`define SPT_CFG_SVH
`define SPT_ADDR_CTRL      4'h0
`define SPT_ADDR_DRIVE     4'h4
`define SPT_ADDR_STATUS    4'h8
`define SPT_CTRL_CHAN_EN   0
`define SPT_CTRL_PLL_PD    1
`define SPT_CTRL_REF_LO    2
`define SPT_CTRL_PREDIV    4
`define SPT_CTRL_MULT_LO   5
`define SPT_CTRL_DBL       8
`define SPT_CTRL_TEN       9
`define SPT_CTRL_ENC_BYP   10
`define SPT_CTRL_XAUI      11
`define SPT_CTRL_GIGE_DIS  12
`define SPT_CTRL_W         13
`define SPT_CTRL_RST       13'h0081
`define SPT_DRIVE_TERM_LO  11
`define SPT_TERM_RST       2'h1
`define SPT_VOD_RST        11'h320
`define SPT_STAT_LOCK      0
`define SPT_STAT_FIFO_LO   1
`define SPT_STAT_UNDERRUN  4
`define SPT_MULT_X2        3'h0
`define SPT_MULT_X5        3'h2
`define SPT_MULT_MAX       3'h6
`define SPT_CLK_MHZ        250
`define SPT_LOCK_NS        400
`define SPT_LOCK_CYCLES    ((`SPT_LOCK_NS * `SPT_CLK_MHZ + 999) / 1000)
`define SPT_FIFO_DEPTH     4
`define SPT_ALIGN_MIN      5'h10
`define SPT_PRBS_SEED      7'h7f
`define SPT_XG_IDLE        8'h07
`define SPT_XG_SEQ         8'h9c
`define SPT_XG_START       8'hfb
`define SPT_XG_TERM        8'hfd
`define SPT_K28_0          8'h1c
`define SPT_K28_3          8'h7c
`define SPT_K28_4          8'h9c
`define SPT_K28_5          8'hbc
`define SPT_K27_7          8'hfb
`define SPT_K29_7          8'hfd
`define SPT_K30_7          8'hfe
`define SPT_D21_5          8'hb5
`define SPT_D2_2           8'h42
`define SPT_D5_6           8'hc5
`define SPT_D16_2          8'h50
`endif

// ---- spt_enc8b10b.sv ----
// combinational 8b/10b encoder with running disparity in and out
`timescale 1ns/1ns
module spt_enc8b10b (
	input  wire logic [7:0] data,
	input  wire logic       is_k,
	input  wire logic       rd_in,
	output logic      [9:0] code,
	output logic            rd_out
);
	import spt_pkg::*;
	localparam logic [5:0] T6 [32] = '{
		6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
		6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
		6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
		6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
	localparam logic [3:0] T4 [8] = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
	logic [5:0] b6;
	logic [3:0] b4;
	logic [4:0] x;
	logic [2:0] y;
	logic       unb6;
	logic       unb4;
	logic       rd6;
	logic       alt7;
	always_comb begin
		x = data[4:0];
		y = data[7:5];
		b6 = T6[x];
		if (is_k && (x == 5'h1c)) begin
			b6 = 6'h0f;
		end
		unb6 = ($countones(b6) != 3);
		if (unb6 && rd_in) begin
			b6 = ~b6;
		end else if ((x == 5'h07) && rd_in) begin
			b6 = 6'h07;
		end
		rd6 = rd_in ^ unb6;
		b4 = T4[y];
		alt7 = (y == 3'h7) && (is_k || (!rd6 && (x == 5'h11 || x == 5'h12 || x == 5'h14))
			|| (rd6 && (x == 5'h0b || x == 5'h0d || x == 5'h0e)));
		if (alt7) begin
			b4 = 4'h7;
		end
		if (is_k && !rd6 && (y == 3'h1 || y == 3'h2 || y == 3'h5 || y == 3'h6)) begin
			b4 = ~b4;
		end
		unb4 = ($countones(b4) != 2);
		if (unb4 && rd6) begin
			b4 = ~b4;
		end else if ((y == 3'h3) && rd6) begin
			b4 = 4'h3;
		end
		code = {b4[0], b4[1], b4[2], b4[3], b6[0], b6[1], b6[2], b6[3], b6[4], b6[5]};
		rd_out = rd6 ^ unb4;
	end
endmodule

// ---- spt_fabric_model.sv ----
// fabric source model that holds a word and counts fabric ticks
`timescale 1ns/1ns
module spt_fabric_model (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        fabric_tick,
	input  wire logic [19:0] word,
	input  wire logic [1:0]  flags,
	output logic      [19:0] tx_data,
	output logic      [1:0]  tx_ctrl,
	output logic      [15:0] ticks
);
	// words follow ref_clk, so the fabric side is frequency locked
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			tx_data <= 20'h00000;
			tx_ctrl <= 2'h0;
			ticks   <= 16'h0000;
		end else begin
			tx_data <= word;
			tx_ctrl <= flags;
			ticks   <= ticks + {15'h0000, fabric_tick};
		end
	end
endmodule

// ---- spt_pkg.sv ----
// shared types for the transmit pcs path
package spt_pkg;
	typedef enum logic [1:0] {SPT_REF_PIN, SPT_REF_FABRIC, SPT_REF_XCVR, SPT_REF_NONE} spt_ref_e;
	typedef enum logic {SPT_HALF_LO, SPT_HALF_HI} spt_half_e;
	typedef logic [10:0] spt_sym_t;
endpackage

// ---- spt_tx_pcs.sv ----
// transmit pcs path: pll model, phase fifo, byte serializer, protocol map, encoder, serializer
`timescale 1ns/1ns
`include "spt_cfg.svh"
module spt_tx_pcs #(
	parameter int          FIFO_DEPTH  = `SPT_FIFO_DEPTH,
	parameter int unsigned LOCK_CYCLES = `SPT_LOCK_CYCLES
) (
	input  wire logic                  ref_clk,
	input  wire logic                  reset,
	input  wire logic [3:0]            avs_address,
	input  wire logic                  avs_read,
	input  wire logic                  avs_write,
	input  wire logic [31:0]           avs_writedata,
	output logic      [31:0]           avs_readdata,
	output logic                       avs_waitrequest,
	input  wire logic                  dedicated_ref_pin_ok,
	input  wire logic                  user_fabric_ref_ok,
	input  wire logic                  xcvr_line_ref_ok,
	input  wire logic [19:0]           tx_data,
	input  wire logic [1:0]            tx_ctrl,
	output logic                       fabric_tick,
	output logic                       rx_ref_tick,
	output logic                       pll_locked,
	output logic                       tx_serial,
	output logic      [10:0]           vod_mv,
	output logic      [1:0]            term_sel
);
	import spt_pkg::*;
	localparam int AW = $clog2(FIFO_DEPTH);
	localparam int CW = AW + 1;

	logic [2:0]             ref_s1_q;
	logic [2:0]             ref_s2_q;
	logic [`SPT_CTRL_W-1:0] ctrl_q;
	logic [10:0]            vod_q;
	logic [1:0]             term_q;
	logic                   wait_q;
	logic [31:0]            rdata_q;
	logic [31:0]            rd_mux;
	logic                   wr_ok;
	logic                   underrun_q;
	logic [31:0]            lock_cnt_q;
	logic                   pll_locked_q;
	logic                   pll_on;
	logic                   mult_ok;
	logic                   ref_ok;
	spt_ref_e               ref_sel;
	logic [2:0]             mult_code;
	logic                   dbl;
	logic                   xaui;
	logic                   enc_byp;
	logic                   ten_sym;
	logic [3:0]             sym_len;
	logic [3:0]             bit_cnt_q;
	logic [9:0]             shift_q;
	logic                   word_tick;
	logic                   need_word;
	spt_half_e              half_q;
	logic                   fab_tick_q;
	logic                   ref_tick_q;
	logic [21:0]            fifo_mem [FIFO_DEPTH];
	logic [AW-1:0]          wr_ptr_q;
	logic [AW-1:0]          rd_ptr_q;
	logic [CW-1:0]          fifo_cnt_q;
	logic                   fifo_empty;
	logic                   fifo_full;
	logic                   push;
	logic                   pop;
	logic [21:0]            fword;
	spt_sym_t               fifo_lo;
	spt_sym_t               fifo_hi;
	spt_sym_t               idle_lo;
	spt_sym_t               idle_hi;
	spt_sym_t               sym;
	spt_sym_t               hold_q;
	logic                   sym_k;
	logic [7:0]             sym_d;
	logic                   enc_k;
	logic [7:0]             enc_d;
	logic                   gige_sub;
	logic                   xg_idle;
	logic                   rd_q;
	logic                   rd_next;
	logic                   k28_q;
	logic                   term_seen_q;
	logic [6:0]             prbs_q;
	logic [4:0]             align_cnt_q;
	logic [9:0]             code_enc;
	logic [9:0]             code;
	logic                   code_lsb;
	logic                   stream_q;
	logic                   prev_bit_q;
	logic [2:0]             run_cnt_q;

	function automatic logic vod_legal(input logic [1:0] t, input logic [10:0] v);
		logic ok;
		ok = 1'b0;
		case (t)
			2'h1: ok = v inside {11'h190, 11'h320, 11'h3e8, 11'h4b0, 11'h578, 11'h640};
			2'h2: ok = v inside {11'h1e0, 11'h3c0, 11'h4b0, 11'h5a0};
			2'h3: ok = v inside {11'h258, 11'h4b0, 11'h5dc};
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction

	// reference presence pins pass two flops
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			ref_s1_q <= 3'h0;
			ref_s2_q <= 3'h0;
		end else begin
			ref_s1_q <= {xcvr_line_ref_ok, user_fabric_ref_ok, dedicated_ref_pin_ok};
			ref_s2_q <= ref_s1_q;
		end
	end

	assign ref_sel   = spt_ref_e'(ctrl_q[`SPT_CTRL_REF_LO +: 2]);
	assign mult_code = ctrl_q[`SPT_CTRL_MULT_LO +: 3];
	assign dbl       = ctrl_q[`SPT_CTRL_DBL];
	assign xaui      = ctrl_q[`SPT_CTRL_XAUI];
	assign enc_byp   = ctrl_q[`SPT_CTRL_ENC_BYP];
	assign ten_sym   = enc_byp && ctrl_q[`SPT_CTRL_TEN];
	assign pll_on    = ctrl_q[`SPT_CTRL_CHAN_EN] && !ctrl_q[`SPT_CTRL_PLL_PD];
	assign mult_ok   = (mult_code <= `SPT_MULT_MAX) && (((mult_code != `SPT_MULT_X2)
		&& (mult_code != `SPT_MULT_X5)) || (ctrl_q[`SPT_CTRL_PREDIV]
		&& (ref_sel == SPT_REF_PIN)));

	always_comb begin
		unique case (ref_sel)
			SPT_REF_PIN:    ref_ok = ref_s2_q[0];
			SPT_REF_FABRIC: ref_ok = ref_s2_q[1];
			SPT_REF_XCVR:   ref_ok = ref_s2_q[2];
			SPT_REF_NONE:   ref_ok = 1'b0;
		endcase
	end

	// pll lock model
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			lock_cnt_q <= 32'h0;
			pll_locked_q <= 1'b0;
		end else if (!(pll_on && mult_ok && ref_ok)) begin
			lock_cnt_q <= 32'h0;
			pll_locked_q <= 1'b0;
		end else if (lock_cnt_q != LOCK_CYCLES - 1) begin
			lock_cnt_q <= lock_cnt_q + 32'h1;
		end else begin
			pll_locked_q <= 1'b1;
		end
	end

	// avalon slave, one wait state per access
	assign wr_ok = avs_write && !wait_q;
	always_comb begin
		case (avs_address)
			`SPT_ADDR_CTRL:   rd_mux = {{(32-`SPT_CTRL_W){1'b0}}, ctrl_q};
			`SPT_ADDR_DRIVE:  rd_mux = {19'h0, term_q, vod_q};
			`SPT_ADDR_STATUS: rd_mux = {27'h0, underrun_q, 3'(fifo_cnt_q), pll_locked_q};
			default:          rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			wait_q <= 1'b1;
			rdata_q <= 32'h0;
		end else begin
			wait_q <= !((avs_read || avs_write) && wait_q);
			if (avs_read && wait_q) begin
				rdata_q <= rd_mux;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			ctrl_q <= `SPT_CTRL_RST;
		end else if (wr_ok && (avs_address == `SPT_ADDR_CTRL)) begin
			ctrl_q <= avs_writedata[`SPT_CTRL_W-1:0];
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			vod_q <= `SPT_VOD_RST;
			term_q <= `SPT_TERM_RST;
		end else if (wr_ok && (avs_address == `SPT_ADDR_DRIVE)
			&& vod_legal(avs_writedata[`SPT_DRIVE_TERM_LO +: 2], avs_writedata[10:0])) begin
			vod_q <= avs_writedata[10:0];
			term_q <= avs_writedata[`SPT_DRIVE_TERM_LO +: 2];
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			underrun_q <= 1'b0;
		end else if (need_word && fifo_empty) begin
			underrun_q <= 1'b1;
		end else if (wr_ok && (avs_address == `SPT_ADDR_STATUS)
			&& avs_writedata[`SPT_STAT_UNDERRUN]) begin
			underrun_q <= 1'b0;
		end
	end

	// symbol timing and clock ticks
	assign sym_len   = (enc_byp && !ctrl_q[`SPT_CTRL_TEN]) ? 4'h8 : 4'ha;
	assign word_tick = pll_locked_q && (bit_cnt_q == 4'h0);
	assign need_word = word_tick && (!dbl || (half_q == SPT_HALF_LO));

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			half_q <= SPT_HALF_LO;
			fab_tick_q <= 1'b0;
			ref_tick_q <= 1'b0;
		end else begin
			fab_tick_q <= word_tick && (!dbl || (half_q == SPT_HALF_HI));
			ref_tick_q <= word_tick;
			if (!dbl || !pll_locked_q) begin
				half_q <= SPT_HALF_LO;
			end else if (word_tick) begin
				half_q <= (half_q == SPT_HALF_LO) ? SPT_HALF_HI : SPT_HALF_LO;
			end
		end
	end

	// phase compensation fifo, never bypassed
	assign fifo_empty = (fifo_cnt_q == CW'(0));
	assign fifo_full  = (fifo_cnt_q == CW'(FIFO_DEPTH));
	assign push       = fab_tick_q && !fifo_full;
	assign pop        = need_word && !fifo_empty;
	assign fword      = fifo_mem[rd_ptr_q];

	always_ff @(posedge ref_clk) begin
		if (push) begin
			fifo_mem[wr_ptr_q] <= {tx_ctrl, tx_data};
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			fifo_cnt_q <= '0;
		end else if (!pll_locked_q) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			fifo_cnt_q <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == AW'(FIFO_DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == AW'(FIFO_DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
			end
			fifo_cnt_q <= fifo_cnt_q + CW'(push) - CW'(pop);
		end
	end

	// byte serializer: low half first, high half held for the next slot
	always_comb begin
		fifo_lo = {fword[20], ten_sym ? fword[9:0] : {2'h0, fword[7:0]}};
		fifo_hi = {fword[21], ten_sym ? fword[19:10] : {2'h0, fword[15:8]}};
		idle_lo = xaui ? {1'b1, 2'h0, `SPT_XG_IDLE} : {1'b1, 2'h0, `SPT_K28_5};
		idle_hi = xaui ? {1'b1, 2'h0, `SPT_XG_IDLE} : {1'b0, 2'h0, `SPT_D16_2};
		if (!need_word) begin
			sym = hold_q;
		end else begin
			sym = fifo_empty ? idle_lo : fifo_lo;
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			hold_q <= '0;
		end else if (need_word) begin
			hold_q <= fifo_empty ? idle_hi : fifo_hi;
		end
	end

	// protocol state machine
	assign sym_k = sym[10];
	assign sym_d = sym[7:0];
	always_comb begin
		enc_k = sym_k;
		enc_d = sym_d;
		gige_sub = 1'b0;
		xg_idle = 1'b0;
		if (xaui) begin
			if (sym_k) begin
				case (sym_d)
					`SPT_XG_IDLE: begin
						xg_idle = 1'b1;
						if (align_cnt_q == 5'h0) begin
							enc_d = `SPT_K28_3;
						end else if (term_seen_q || prbs_q[0]) begin
							enc_d = `SPT_K28_5;
						end else begin
							enc_d = `SPT_K28_0;
						end
					end
					`SPT_XG_SEQ:   enc_d = `SPT_K28_4;
					`SPT_XG_START: enc_d = `SPT_K27_7;
					`SPT_XG_TERM:  enc_d = `SPT_K29_7;
					default:       enc_d = `SPT_K30_7;
				endcase
			end
		end else if (!ctrl_q[`SPT_CTRL_GIGE_DIS] && k28_q && !sym_k
			&& (sym_d != `SPT_D21_5) && (sym_d != `SPT_D2_2)) begin
			gige_sub = 1'b1;
			enc_d = rd_q ? `SPT_D16_2 : `SPT_D5_6;
		end
	end

	spt_enc8b10b u_enc (
		.data   (enc_d),
		.is_k   (enc_k),
		.rd_in  (rd_q),
		.code   (code_enc),
		.rd_out (rd_next)
	);

	assign code     = enc_byp ? sym[9:0] : code_enc;
	assign code_lsb = code[0];

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			rd_q <= 1'b0;
			k28_q <= 1'b0;
			term_seen_q <= 1'b0;
			prbs_q <= `SPT_PRBS_SEED;
			align_cnt_q <= `SPT_ALIGN_MIN;
		end else if (word_tick) begin
			rd_q <= enc_byp ? rd_q : rd_next;
			k28_q <= !xaui && !enc_byp && sym_k && (sym_d == `SPT_K28_5);
			term_seen_q <= xaui && sym_k && (sym_d == `SPT_XG_TERM);
			if (xg_idle) begin
				prbs_q <= {prbs_q[5:0], prbs_q[6] ^ prbs_q[5]};
				if (align_cnt_q == 5'h0) begin
					align_cnt_q <= `SPT_ALIGN_MIN | {1'b0, prbs_q[3:0]};
				end else begin
					align_cnt_q <= align_cnt_q - 5'h1;
				end
			end
		end
	end

	// serializer, lsb first
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			bit_cnt_q <= 4'h0;
			shift_q <= 10'h0;
		end else if (!pll_locked_q) begin
			bit_cnt_q <= 4'h0;
			shift_q <= 10'h0;
		end else if (word_tick) begin
			bit_cnt_q <= sym_len - 4'h1;
			shift_q <= code;
		end else begin
			bit_cnt_q <= bit_cnt_q - 4'h1;
			shift_q <= {1'b0, shift_q[9:1]};
		end
	end

	// run length watch on the encoded line
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			stream_q <= 1'b0;
			prev_bit_q <= 1'b0;
			run_cnt_q <= 3'h0;
		end else begin
			stream_q <= pll_locked_q && !enc_byp && (stream_q || word_tick);
			prev_bit_q <= shift_q[0];
			if (!stream_q) begin
				run_cnt_q <= 3'h0;
			end else if ((shift_q[0] == prev_bit_q) && (run_cnt_q != 3'h0)) begin
				run_cnt_q <= (run_cnt_q == 3'h7) ? run_cnt_q : run_cnt_q + 3'h1;
			end else begin
				run_cnt_q <= 3'h1;
			end
		end
	end

	assign avs_readdata    = rdata_q;
	assign avs_waitrequest = wait_q;
	assign fabric_tick     = fab_tick_q;
	assign rx_ref_tick     = ref_tick_q;
	assign pll_locked      = pll_locked_q;
	assign tx_serial       = shift_q[0];
	assign vod_mv          = vod_q;
	assign term_sel        = term_q;

	property p_fab_half;
		@(posedge ref_clk) disable iff (reset)
		word_tick && dbl && (half_q == SPT_HALF_LO) |=> !fab_tick_q;
	endproperty
	a_fab_half: assert property (p_fab_half) else $error("fabric tick on low half");
	property p_pll_off;
		@(posedge ref_clk) disable iff (reset) !pll_on |=> !pll_locked_q;
	endproperty
	a_pll_off: assert property (p_pll_off) else $error("pll locked while off");
	property p_lock_time;
		@(posedge ref_clk) disable iff (reset)
		$rose(pll_locked_q) |-> (lock_cnt_q == LOCK_CYCLES - 1) && $past(pll_on);
	endproperty
	a_lock_time: assert property (p_lock_time) else $error("lock before count");
	property p_mult_bad;
		@(posedge ref_clk) disable iff (reset) !mult_ok |=> !pll_locked_q;
	endproperty
	a_mult_bad: assert property (p_mult_bad) else $error("locked with bad multiplier");
	property p_fifo_bound;
		@(posedge ref_clk) disable iff (reset) fifo_cnt_q <= CW'(FIFO_DEPTH);
	endproperty
	a_fifo_bound: assert property (p_fifo_bound) else $error("fifo over depth");
	property p_single;
		@(posedge ref_clk) disable iff (reset) !dbl && word_tick |=> fab_tick_q;
	endproperty
	a_single: assert property (p_single) else $error("single width skipped a word");
	property p_run;
		@(posedge ref_clk) disable iff (reset) run_cnt_q <= 3'h5;
	endproperty
	a_run: assert property (p_run) else $error("run length above five");
	property p_idle_rd;
		@(posedge ref_clk) disable iff (reset) word_tick && gige_sub && !enc_byp |=> !rd_q;
	endproperty
	a_idle_rd: assert property (p_idle_rd) else $error("idle set ends positive");
	property p_start;
		@(posedge ref_clk) disable iff (reset)
		xaui && sym_k && (sym_d == `SPT_XG_START) |-> enc_k && (enc_d == `SPT_K27_7);
	endproperty
	a_start: assert property (p_start) else $error("start not K27.7");
	property p_align;
		@(posedge ref_clk) disable iff (reset)
		word_tick && xg_idle && (align_cnt_q == 5'h0) |-> (enc_d == `SPT_K28_3) ##1 align_cnt_q >= 5'h10;
	endproperty
	a_align: assert property (p_align) else $error("alignment spacing wrong");
	property p_lsb;
		@(posedge ref_clk) disable iff (reset) word_tick |=> tx_serial == $past(code_lsb);
	endproperty
	a_lsb: assert property (p_lsb) else $error("first bit not lsb");
	property p_vod;
		@(posedge ref_clk) disable iff (reset) vod_legal(term_q, vod_q);
	endproperty
	a_vod: assert property (p_vod) else $error("illegal amplitude held");
endmodule

// ---- testbench.sv ----
// self-checking bench for the transmit pcs path
`timescale 1ns/1ns
module testbench;
	logic        ref_clk = 1'b0;
	logic        reset = 1'b1;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        pin_ok = 1'b1;
	logic        fab_ok = 1'b0;
	logic        line_ok = 1'b1;
	logic [19:0] word = 20'h0;
	logic [1:0]  flags = 2'h0;
	logic [19:0] tx_data;
	logic [1:0]  tx_ctrl;
	logic [15:0] ticks;
	logic        fabric_tick, rx_ref_tick, pll_locked, tx_serial;
	logic [10:0] vod_mv;
	logic [1:0]  term_sel;
	logic [31:0] q;
	logic [6:0]  sh = 7'h0;
	int          err_total = 0;
	int          cmp_count = 0;
	int          run = 0;
	int          commas = 0;
	logic        mon = 1'b0;
	logic        prev = 1'b0;
	initial forever #2 ref_clk = ~ref_clk;
	spt_tx_pcs #(.FIFO_DEPTH(4), .LOCK_CYCLES(4)) dut (.ref_clk(ref_clk), .reset(reset),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .dedicated_ref_pin_ok(pin_ok),
		.user_fabric_ref_ok(fab_ok), .xcvr_line_ref_ok(line_ok), .tx_data(tx_data),
		.tx_ctrl(tx_ctrl), .fabric_tick(fabric_tick), .rx_ref_tick(rx_ref_tick),
		.pll_locked(pll_locked), .tx_serial(tx_serial), .vod_mv(vod_mv), .term_sel(term_sel));
	spt_fabric_model fab (.ref_clk(ref_clk), .reset(reset), .fabric_tick(fabric_tick),
		.word(word), .flags(flags), .tx_data(tx_data), .tx_ctrl(tx_ctrl), .ticks(ticks));
	// run length and comma watch on the serial line
	always @(posedge ref_clk) begin
		sh <= {sh[5:0], tx_serial};
		run = (tx_serial === prev) ? run + 1 : 1;
		prev = tx_serial;
		if (mon && run > 5) begin
			err_total++;
			$display("BAD run_length exp 5 got %0d", run);
		end
		if (sh === 7'b0011111 || sh === 7'b1100000)
			commas++;
	end
	task end_of_test;
		if (err_total == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			err_total++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do begin
			@(posedge ref_clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge ref_clk);
	endtask
	task lock_wait(input logic e);
		repeat (200) begin
			@(posedge ref_clk);
			if (pll_locked === e)
				break;
		end
		chk("pll_locked", {31'h0, e}, {31'h0, pll_locked});
	endtask
	task t_reset;
		bus(1'b0, 4'h0, 32'h0);
		chk("ctrl", 32'h00000081, q);
		bus(1'b0, 4'h4, 32'h0);
		chk("drive", 32'h00000b20, q);
		chk("vod", 32'h320, {21'h0, vod_mv});
	endtask
	task t_drive;
		bus(1'b1, 4'h4, 32'h00001ddc);
		chk("vod", 32'h5dc, {21'h0, vod_mv});
		chk("term", 32'h3, {30'h0, term_sel});
		bus(1'b1, 4'h4, 32'h00001be8);
		bus(1'b1, 4'h4, 32'h00000320);
		chk("vod", 32'h5dc, {21'h0, vod_mv});
		bus(1'b1, 4'h4, 32'h00000c80);
		chk("vod", 32'h5dc, {21'h0, vod_mv});
		bus(1'b1, 4'h4, 32'h00000cb0);
		chk("vod", 32'h4b0, {21'h0, vod_mv});
		chk("term", 32'h1, {30'h0, term_sel});
		bus(1'b1, 4'hc, 32'hffffffff);
		bus(1'b0, 4'hc, 32'h0);
		chk("unmapped", 32'h0, q);
		bus(1'b0, 4'h0, 32'h0);
		chk("ctrl", 32'h00000081, q);
	endtask
	task t_pll;
		logic [15:0] t0;
		bus(1'b1, 4'h0, 32'h00000025);
		repeat (5) @(posedge ref_clk);
		t0 = ticks;
		repeat (25) @(posedge ref_clk);
		chk("pll_locked", 32'h0, {31'h0, pll_locked});
		chk("ticks", {16'h0, t0}, {16'h0, ticks});
		bus(1'b1, 4'h0, 32'h00000029);
		lock_wait(1'b1);
		bus(1'b1, 4'h0, 32'h00000001);
		lock_wait(1'b0);
		bus(1'b1, 4'h0, 32'h00000011);
		lock_wait(1'b1);
		bus(1'b1, 4'h0, 32'h00000013);
		lock_wait(1'b0);
		bus(1'b1, 4'h0, 32'h00000021);
		lock_wait(1'b1);
		bus(1'b1, 4'h8, 32'h0);
		chk("stat_lock", 32'h1, {31'h0, q[0]});
	endtask
	task t_gap(input logic [31:0] c, input int e);
		int n;
		bus(1'b1, 4'h0, c);
		lock_wait(1'b1);
		repeat (60) @(posedge ref_clk);
		for (n = 0; n < 100 && fabric_tick !== 1'b1; n++)
			@(posedge ref_clk);
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (fabric_tick !== 1'b1 && n < 100);
		chk("tick_gap", e, n);
	endtask
	task t_lsb;
		int n;
		word <= 20'h0000b;
		t_gap(32'h00000681, 10);
		repeat (20) @(posedge ref_clk);
		chk("ref_tick", 32'h1, {31'h0, rx_ref_tick});
		for (n = 0; n < 10; n++) begin
			q[n] = tx_serial;
			@(posedge ref_clk);
		end
		chk("lsb_first", 32'h0000000b, {22'h0, q[9:0]});
	endtask
	task t_idle;
		int n;
		word <= 20'h000bc;
		flags <= 2'h1;
		t_gap(32'h00000181, 20);
		repeat (40) @(posedge ref_clk);
		for (n = 0; n < 20; n++) begin
			q[n] = tx_serial;
			@(posedge ref_clk);
		end
		chk("idle_set", 32'h0005f289, {12'h0, q[19:0]});
		t_gap(32'h00001181, 20);
		repeat (40) @(posedge ref_clk);
		for (n = 0; n < 10; n++) begin
			q[n] = tx_serial;
			@(posedge ref_clk);
		end
		chk("idle_conv_off", 32'h1, {31'h0, q[9:0] == 10'h346 || q[9:0] == 10'h0b9});
	endtask
	task t_enc;
		word <= 20'h00000;
		t_gap(32'h00000081, 10);
		mon <= 1'b1;
		commas = 0;
		repeat (400) @(posedge ref_clk);
		word <= 20'h000ff;
		repeat (400) @(posedge ref_clk);
		chk("data_commas", 32'h0, commas);
		mon <= 1'b0;
		word <= 20'h00007;
		flags <= 2'h3;
		t_gap(32'h00000881, 10);
		mon <= 1'b1;
		commas = 0;
		repeat (1200) @(posedge ref_clk);
		chk("idle_commas", 32'h1, {31'h0, commas > 0});
		mon <= 1'b0;
	endtask
	initial begin
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		t_reset;
		t_drive;
		t_pll;
		t_lsb;
		t_gap(32'h00000781, 20);
		t_gap(32'h00000481, 8);
		t_enc;
		t_idle;
		end_of_test;
	end
	initial begin
		#100000;
		err_total++;
		end_of_test;
	end
endmodule
